// ==== hdl/lap_fifo.sv ====
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lap_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [AW-1:0]    wr_q;          // write pointer
  logic [AW-1:0]    rd_q;          // read pointer
  logic [AW:0]      cnt_q;         // fill level
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  // pointers and level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== hdl/lap_host_port.sv ====
// link adaptor host register port with bit-serial link
`timescale 1ns/1ps
`default_nettype none
module lap_host_port #(
  parameter int BIT_CYCLES = lap_pkg::BIT_CYCLES,
  parameter int FIFO_DEPTH = lap_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       MCLK_I,
  input  wire logic       SRST_I,
  // host bus
  input  wire logic       CHIP_SELECT_N_I,
  input  wire logic       READ_WRITE_SEL_I,
  input  wire logic [1:0] REG_SELECT_I,
  input  wire logic [7:0] HOST_BUS_I,
  output logic      [7:0] HOST_BUS_O,
  output logic            HOST_BUS_OE_N_O,
  // interrupts
  output logic            RX_IRQ_O,
  output logic            TX_IRQ_O,
  // serial link
  input  wire logic       LINK_IN_I,
  output logic            LINK_OUT_O
);
  ////////////////////////////////////////////////////////////////////
  // declarations
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} lap_tx_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BITS = 2'b10} lap_rx_t;

  logic        cs_prev_q;      // chip select last cycle
  logic        cs_fall;        // access begins
  logic        cs_rise;        // access ends
  logic [1:0]  sel_q;          // latched register select
  logic        rd_q;           // latched read/write
  logic        rx_dp_q;        // data-present flag
  logic        rx_ie_q;        // receive interrupt enable
  logic        tx_rdy_q;       // output-ready flag
  logic        tx_ie_q;        // transmit interrupt enable
  logic [7:0]  rx_data_q;      // input data register
  logic        wr_open_q;      // output write in progress
  logic        ack_req_q;      // acknowledge owed to link
  logic        await_ack_q;    // data sent, acknowledge awaited
  logic [15:0] div_q;          // bit time divider
  logic        bit_tick;       // one pulse per bit time
  logic        arm_q;          // one tick seen since request
  lap_tx_t     tx_st_q;        // transmitter state
  logic [10:0] tx_sh_q;        // transmit shifter
  logic [3:0]  tx_left_q;      // bits still to send
  logic        start_ack;      // acknowledge packet starts
  logic        start_data;     // data packet starts
  lap_rx_t     rx_st_q;        // receiver state
  logic [15:0] rx_cnt_q;       // cycles to next sample
  logic [3:0]  rx_idx_q;       // received bit index
  logic [7:0]  rx_sh_q;        // receive shifter
  logic        link_prev_q;    // link level last cycle
  logic        rx_done;        // data packet complete
  logic        ack_seen;       // acknowledge received
  logic        rx_rd_fall;     // input data read begins
  logic        tx_wr_fall;     // output data write begins
  logic        f_valid;        // buffer holds a byte
  logic        f_in_ready;     // buffer can take a byte
  logic [7:0]  f_data;         // buffer head

  ////////////////////////////////////////////////////////////////////
  // host access strobes
  assign cs_fall    = cs_prev_q && !CHIP_SELECT_N_I;
  assign cs_rise    = !cs_prev_q && CHIP_SELECT_N_I;
  assign rx_rd_fall = cs_fall && READ_WRITE_SEL_I &&
                      (REG_SELECT_I == lap_pkg::SEL_RX_DATA);
  assign tx_wr_fall = cs_fall && !READ_WRITE_SEL_I &&
                      (REG_SELECT_I == lap_pkg::SEL_TX_DATA);

  // chip select edge history
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= CHIP_SELECT_N_I;
    end
  end

  // select and direction latched as access begins
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      sel_q <= 2'h0;
      rd_q  <= 1'b1;
    end else if (cs_fall) begin
      sel_q <= REG_SELECT_I;
      rd_q  <= READ_WRITE_SEL_I;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data bus, driven only during selected reads
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      HOST_BUS_OE_N_O <= 1'b1;
      HOST_BUS_O      <= 8'h00;
    end else if (cs_fall && READ_WRITE_SEL_I) begin
      HOST_BUS_OE_N_O <= 1'b0;
      if (REG_SELECT_I == lap_pkg::SEL_RX_DATA) begin
        HOST_BUS_O <= rx_data_q;
      end else if (REG_SELECT_I == lap_pkg::SEL_RX_STAT) begin
        HOST_BUS_O <= {6'h00, rx_ie_q, rx_dp_q};
      end else if (REG_SELECT_I == lap_pkg::SEL_TX_STAT) begin
        HOST_BUS_O <= {6'h00, tx_ie_q, tx_rdy_q};
      end else begin
        HOST_BUS_O <= 8'h00;
      end
    end else if (CHIP_SELECT_N_I) begin
      HOST_BUS_OE_N_O <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status writes take data as chip select rises
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      rx_ie_q <= lap_pkg::RX_IE_RST;
      tx_ie_q <= lap_pkg::TX_IE_RST;
    end else if (cs_rise && !rd_q) begin
      if (sel_q == lap_pkg::SEL_RX_STAT) begin
        rx_ie_q <= HOST_BUS_I[lap_pkg::STAT_IE_BIT];
      end else if (sel_q == lap_pkg::SEL_TX_STAT) begin
        tx_ie_q <= HOST_BUS_I[lap_pkg::STAT_IE_BIT];
      end
    end
  end

  // data-present: packet arrival wins over a read
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      rx_dp_q <= 1'b0;
    end else if (rx_done) begin
      rx_dp_q <= 1'b1;
    end else if (rx_rd_fall) begin
      rx_dp_q <= 1'b0;
    end
  end

  // acknowledge owed after input data read ends
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      ack_req_q <= 1'b0;
    end else if (cs_rise && rd_q && sel_q == lap_pkg::SEL_RX_DATA) begin
      ack_req_q <= 1'b1;
    end else if (start_ack) begin
      ack_req_q <= 1'b0;
    end
  end

  // output write window from select to deselect
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      wr_open_q <= 1'b0;
    end else if (tx_wr_fall) begin
      wr_open_q <= 1'b1;
    end else if (cs_rise) begin
      wr_open_q <= 1'b0;
    end
  end

  // output-ready: low from write until acknowledge returns
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      tx_rdy_q <= lap_pkg::RDY_RST;
    end else if (tx_wr_fall) begin
      tx_rdy_q <= 1'b0;
    end else if (!wr_open_q && !f_valid && !await_ack_q &&
                 tx_st_q == TX_IDLE) begin
      tx_rdy_q <= 1'b1;
    end
  end

  // interrupt outputs from enable and flag
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      RX_IRQ_O <= 1'b0;
      TX_IRQ_O <= lap_pkg::TX_IRQ_RST;
    end else begin
      RX_IRQ_O <= rx_ie_q && rx_dp_q && !rx_rd_fall;
      TX_IRQ_O <= tx_ie_q && tx_rdy_q && !tx_wr_fall;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transmit buffer, filled on deselect of a data write
  lap_fifo #(
    .WIDTH (lap_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) lap_fifo_inst (
    .clk_i       (MCLK_I),
    .rst_i       (SRST_I),
    .in_valid_i  (cs_rise && !rd_q && sel_q == lap_pkg::SEL_TX_DATA),
    .in_ready_o  (f_in_ready),
    .in_data_i   (HOST_BUS_I),
    .out_valid_o (f_valid),
    .out_ready_i (start_data),
    .out_data_o  (f_data)
  );

  ////////////////////////////////////////////////////////////////////
  // bit time divider
  assign bit_tick = (div_q == 16'(BIT_CYCLES - 1));
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || bit_tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // start one to two bit times after a request; acknowledge first
  assign start_ack  = bit_tick && arm_q && tx_st_q == TX_IDLE &&
                      ack_req_q;
  assign start_data = bit_tick && arm_q && tx_st_q == TX_IDLE &&
                      !ack_req_q && f_valid && !await_ack_q;

  // arm on a request's first tick; a new ack request restarts it
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      arm_q <= 1'b0;
    end else if (start_ack || start_data ||
                 (cs_rise && rd_q && sel_q == lap_pkg::SEL_RX_DATA)) begin
      arm_q <= 1'b0;
    end else if (bit_tick && tx_st_q == TX_IDLE &&
                 (ack_req_q || (f_valid && !await_ack_q))) begin
      arm_q <= 1'b1;
    end
  end

  // transmitter: shift packets out lsb first
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      tx_st_q   <= TX_IDLE;
      tx_sh_q   <= 11'h000;
      tx_left_q <= 4'h0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (start_ack) begin
            tx_sh_q   <= 11'h001;   // start, ack type
            tx_left_q <= 4'(lap_pkg::ACK_PKT_BITS);
            tx_st_q   <= TX_SEND;
          end else if (start_data) begin
            tx_sh_q   <= {1'b0, f_data, 2'h3};
            tx_left_q <= 4'(lap_pkg::DATA_PKT_BITS);
            tx_st_q   <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (bit_tick) begin
            tx_sh_q   <= {1'b0, tx_sh_q[10:1]};
            tx_left_q <= tx_left_q - 4'h1;
            if (tx_left_q == 4'h1) begin
              tx_st_q <= TX_IDLE;
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end
  assign LINK_OUT_O = tx_sh_q[0];

  // waiting for the acknowledge of a sent byte
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      await_ack_q <= 1'b0;
    end else if (start_data) begin
      await_ack_q <= 1'b1;
    end else if (ack_seen) begin
      await_ack_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receiver: sample mid-bit after a rising start edge
  assign ack_seen = rx_st_q == RX_BITS && rx_cnt_q == 16'h0000 &&
                    rx_idx_q == 4'h1 && !LINK_IN_I;
  assign rx_done  = rx_st_q == RX_BITS && rx_cnt_q == 16'h0000 &&
                    rx_idx_q == 4'h9;

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      link_prev_q <= 1'b0;
    end else begin
      link_prev_q <= LINK_IN_I;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      rx_st_q  <= RX_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_idx_q <= 4'h0;
      rx_sh_q  <= 8'h00;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          if (LINK_IN_I && !link_prev_q) begin
            rx_cnt_q <= 16'(BIT_CYCLES + BIT_CYCLES / 2 - 2);
            rx_idx_q <= 4'h1;
            rx_st_q  <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end else if (ack_seen || rx_done) begin
            rx_st_q <= RX_IDLE;
          end else begin
            if (rx_idx_q != 4'h1) begin
              rx_sh_q <= {LINK_IN_I, rx_sh_q[7:1]};
            end
            rx_idx_q <= rx_idx_q + 4'h1;
            rx_cnt_q <= 16'(BIT_CYCLES - 1);
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // input data register takes only data packets
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      rx_data_q <= 8'h00;
    end else if (rx_done) begin
      rx_data_q <= {LINK_IN_I, rx_sh_q[7:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);

  a_rd_drops_irq: assert property (rx_rd_fall && !rx_done |=> ##1 !RX_IRQ_O)
    else $error("receive interrupt not dropped by read");
  a_pkt_sets_dp: assert property (rx_done |=> rx_dp_q ##1
    (RX_IRQ_O || $past(!rx_ie_q || rx_rd_fall)))
    else $error("data-present not set by packet");
  a_rx_irq_gate: assert property (!rx_ie_q ##1 !rx_ie_q |-> !RX_IRQ_O)
    else $error("receive interrupt high while disabled");
  a_ack_no_early: assert property (cs_rise && rd_q && sel_q == lap_pkg::SEL_RX_DATA |-> !start_ack [*8])
    else $error("acknowledge started too early");
  a_ack_in_time: assert property (cs_rise && rd_q && sel_q == lap_pkg::SEL_RX_DATA |-> ##[1:330] start_ack)
    else $error("acknowledge late");
  a_wr_clr_ready: assert property (tx_wr_fall |=> !tx_rdy_q ##1 !TX_IRQ_O)
    else $error("output-ready not cleared by write");
  a_ready_waits: assert property (await_ack_q |-> !tx_rdy_q)
    else $error("output-ready high before acknowledge");
  a_data_in_time: assert property (cs_rise && !rd_q && sel_q == lap_pkg::SEL_TX_DATA && !await_ack_q && tx_st_q == TX_IDLE && !ack_req_q |-> ##[1:110] start_data)
    else $error("data packet late");
  a_tx_irq_gate: assert property (!tx_ie_q ##1 !tx_ie_q |-> !TX_IRQ_O)
    else $error("transmit interrupt high while disabled");
  a_bus_drive: assert property (!HOST_BUS_OE_N_O |-> $past(!CHIP_SELECT_N_I) && rd_q)
    else $error("bus driven outside a read");
  a_ack_keeps_data: assert property (ack_seen |=> $stable(rx_data_q))
    else $error("acknowledge changed input data");

  c_rx_read: cover property (rx_done ##[1:200] rx_rd_fall);
  c_tx_cycle: cover property (start_data ##[1:900] ack_seen);
  c_ack_sent: cover property (start_ack);
endmodule
`default_nettype wire

// ==== hdl/lap_pkg.sv ====
// package of constants for the link adaptor host port
// What this block does
// - link data packet sets data-present; read clears
// - receive interrupt equals enable and data-present
// - input data read or reset drops receive interrupt
// - input data read clears flag, sends acknowledge
// - acknowledge starts 0.8 to 2 bits after deselect
// - receive interrupt within 13 bits of packet start
// - written output byte goes out as data packet
// - output data reads return undefined, no effect
// - output-ready empty buffer, reset high, write clears
// - output-ready waits for transmission and acknowledge
// - transmit interrupt equals enable and output-ready
// - output write drops transmit interrupt; reset raises
// - data packet starts 0.8 to 2 bits after deselect
// - transmit interrupt within 3 bits of acknowledge
// - select lines latched on chip select falling
// - write data captured on chip select rising
// - bus driven only during selected reads
// - input data holds data, never acknowledge
package lap_pkg;
  // register select codes
  localparam logic [1:0] SEL_RX_DATA = 2'h0;
  localparam logic [1:0] SEL_TX_DATA = 2'h1;
  localparam logic [1:0] SEL_RX_STAT = 2'h2;
  localparam logic [1:0] SEL_TX_STAT = 2'h3;
  // status field positions
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_IE_BIT   = 1;
  // reset values
  localparam logic       RX_IE_RST  = 1'b0;
  localparam logic       TX_IE_RST  = 1'b0;
  localparam logic       RDY_RST    = 1'b1;
  localparam logic       TX_IRQ_RST = 1'b1;
  // link timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int BIT_NS        = 100;
  localparam int BIT_CYCLES    = BIT_NS / CLK_PERIOD_NS;
  // packet lengths in bits
  localparam int DATA_PKT_BITS = 11;
  localparam int ACK_PKT_BITS  = 2;
  // transmit buffer
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;
endpackage

// ==== sim/lap_link_peer.sv ====
// link far-end model: sends data and acks, receives packets
`timescale 1ns/1ps
`default_nettype none
module lap_link_peer #(
  parameter int BIT_CYCLES = 8
) (
  // link side
  input  wire logic clk_i,
  input  wire logic link_i,
  output logic      link_o,
  // control
  input  wire logic auto_ack_i
);
  logic [7:0] rx_byte;  // last data byte seen
  int         n_data;   // data packets seen
  int         n_ack;    // acks seen
  realtime    t_rx;     // detected start of last packet seen
  realtime    t_tx;     // start of last packet sent
  bit         busy;     // own transmitter in use

  initial begin
    link_o = 1'b0;
    busy   = 1'b0;
    n_data = 0;
    n_ack  = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // send bits lsb first off the falling edge, idle low after
  task automatic send_bits(input logic [10:0] bits, input int n);
    wait (!busy);
    busy = 1'b1;
    @(negedge clk_i);
    t_tx = $realtime;
    for (int i = 0; i < n; i++) begin
      link_o = bits[i];
      repeat (BIT_CYCLES) @(negedge clk_i);
    end
    link_o = 1'b0;
    busy   = 1'b0;
  endtask

  // data packet: two ones, byte lsb first, stop zero
  task automatic send_data(input logic [7:0] b);
    send_bits({1'b0, b, 2'b11}, 11);
  endtask

  // acknowledge packet: one then zero
  task automatic send_ack();
    send_bits(11'h001, 2);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // receiver: start on a rise, sample each bit mid-time
  initial begin
    forever begin
      @(posedge clk_i iff link_i === 1'b1);
      t_rx = $realtime;
      repeat (BIT_CYCLES / 2 + BIT_CYCLES) @(posedge clk_i);
      if (link_i === 1'b1) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(posedge clk_i);
          rx_byte[i] = link_i;
        end
        repeat (BIT_CYCLES) @(posedge clk_i);
        n_data++;
        // return an ack for each byte when asked to
        if (auto_ack_i) begin
          fork
            send_ack();
          join_none
        end
      end else begin
        n_ack++;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking testbench for the link adaptor host port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int  B  = 8;        // shortened bit time in clocks
  localparam real BT = B * 4.0;  // bit time in ns

  logic       mclk;      // 250 MHz clock
  logic       srst;      // synchronous reset
  logic       cs_n;      // chip select, active low
  logic       rw;        // 1 read, 0 write
  logic [1:0] sel;       // register select
  logic [7:0] bus_in;    // host write data
  logic [7:0] bus_out;   // device read data
  logic       oe_n;      // device bus drive, active low
  logic       rx_irq;    // receive interrupt
  logic       tx_irq;    // transmit interrupt
  logic       link_dn;   // device to peer
  logic       link_up;   // peer to device
  logic       auto_ack;  // peer acks each byte
  int         failures;  // mismatches
  int         n_tests;   // comparisons
  realtime    t_desel;   // time of last chip select release
  realtime    t0;        // saved reference time
  logic [7:0] q;         // scratch read value
  int         n0;        // saved packet count

  lap_host_port #(.BIT_CYCLES(B), .FIFO_DEPTH(lap_pkg::FIFO_DEPTH))
    lap_host_port_inst (
    .MCLK_I(mclk), .SRST_I(srst), .CHIP_SELECT_N_I(cs_n),
    .READ_WRITE_SEL_I(rw), .REG_SELECT_I(sel), .HOST_BUS_I(bus_in),
    .HOST_BUS_O(bus_out), .HOST_BUS_OE_N_O(oe_n), .RX_IRQ_O(rx_irq),
    .TX_IRQ_O(tx_irq), .LINK_IN_I(link_up), .LINK_OUT_O(link_dn));

  lap_link_peer #(.BIT_CYCLES(B)) lap_link_peer_inst (
    .clk_i(mclk), .link_i(link_dn), .link_o(link_up),
    .auto_ack_i(auto_ack));

  // clock
  always #2 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////
  // compare helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_time(input real v, input real lo, input real hi,
                          input string what);
    n_tests++;
    if (v < lo || v > hi) begin
      failures++;
      $display("ERROR %0t %s delay %0.1f ns", $time, what, v);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // one bus cycle: select held 3 cycles low, then 3 high
  task automatic access(input logic [1:0] s, input logic r,
                        input logic [7:0] wd, output logic [7:0] d);
    @(negedge mclk);
    cs_n   = 1'b0;
    sel    = s;
    rw     = r;
    bus_in = wd;
    repeat (3) @(negedge mclk);
    d = bus_out;
    check({7'h00, oe_n}, {7'h00, ~r}, "bus drive in access");
    cs_n    = 1'b1;
    t_desel = $realtime;
    @(negedge mclk);
    bus_in = ~wd;
    repeat (2) @(negedge mclk);
    check({7'h00, oe_n}, 8'h01, "bus drive after access");
  endtask

  task automatic rd_chk(input logic [1:0] s, input logic [7:0] exp);
    logic [7:0] d;
    access(s, 1'b1, 8'h00, d);
    check(d, exp, "register read");
  endtask

  task automatic wr(input logic [1:0] s, input logic [7:0] wd);
    logic [7:0] d;
    access(s, 1'b0, wd, d);
  endtask

  // bounded wait for an interrupt line
  task automatic wait_irq(input bit tx, input int lim);
    for (int i = 0; i < lim && (tx ? tx_irq : rx_irq) !== 1'b1; i++)
      @(negedge mclk);
  endtask

  task automatic finish_test();
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the expected run of under a thousand cycles
  initial begin
    #100000;
    failures++;
    $display("ERROR %0t run did not finish", $time);
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    mclk = 1'b0; srst = 1'b1; cs_n = 1'b1; rw = 1'b1;
    sel = 2'h0; bus_in = 8'h00; auto_ack = 1'b0;
    failures = 0; n_tests = 0;
    repeat (12) @(negedge mclk);
    check({6'h00, rx_irq, tx_irq}, 8'h01, "irq during reset");
    srst = 1'b0;
    repeat (2) @(negedge mclk);
    // reset state
    check({6'h00, rx_irq, tx_irq}, 8'h00, "irq after reset");
    check({7'h00, oe_n}, 8'h01, "bus idle");
    rd_chk(2'h2, 8'h00);
    rd_chk(2'h3, 8'h01);
    // transmit enable on, off, on
    wr(2'h3, 8'h02);
    rd_chk(2'h3, 8'h03);
    check({7'h00, tx_irq}, 8'h01, "tx irq enabled");
    wr(2'h3, 8'h00);
    check({7'h00, tx_irq}, 8'h00, "tx irq disabled");
    wr(2'h3, 8'h02);
    check({7'h00, tx_irq}, 8'h01, "tx irq re-enabled");
    // write to input data and read of output data change nothing
    wr(2'h0, 8'h77);
    rd_chk(2'h2, 8'h00);
    access(2'h1, 1'b1, 8'h00, q);
    rd_chk(2'h3, 8'h03);
    // receive one byte with the interrupt enabled
    wr(2'h2, 8'h02);
    fork
      lap_link_peer_inst.send_data(8'h5a);
    join_none
    wait_irq(1'b0, 14 * B);
    check({7'h00, rx_irq}, 8'h01, "rx irq raised");
    chk_time($realtime - lap_link_peer_inst.t_tx, 0.0, 13 * BT,
             "rx irq");
    repeat (2 * B) @(negedge mclk);
    rd_chk(2'h2, 8'h03);
    wr(2'h2, 8'h00);
    check({7'h00, rx_irq}, 8'h00, "rx irq disabled");
    wr(2'h2, 8'h02);
    check({7'h00, rx_irq}, 8'h01, "rx irq re-enabled");
    n0 = lap_link_peer_inst.n_ack;
    rd_chk(2'h0, 8'h5a);
    t0 = t_desel;
    check({7'h00, rx_irq}, 8'h00, "rx irq after read");
    for (int i = 0; i < 5 * B && lap_link_peer_inst.n_ack == n0; i++)
      @(negedge mclk);
    check(8'(lap_link_peer_inst.n_ack - n0), 8'h01, "ack sent");
    chk_time(lap_link_peer_inst.t_rx - t0, 0.8 * BT, 2 * BT + 8,
             "ack start");
    rd_chk(2'h2, 8'h02);
    // transmit one byte, ack withheld at first
    n0 = lap_link_peer_inst.n_data;
    wr(2'h1, 8'hc3);
    t0 = t_desel;
    check({7'h00, tx_irq}, 8'h00, "tx irq after write");
    rd_chk(2'h3, 8'h02);
    for (int i = 0; i < 14 * B && lap_link_peer_inst.n_data == n0; i++)
      @(negedge mclk);
    check(lap_link_peer_inst.rx_byte, 8'hc3, "sent byte");
    chk_time(lap_link_peer_inst.t_rx - t0, 0.8 * BT, 2 * BT + 8,
             "data start");
    repeat (2 * B) @(negedge mclk);
    rd_chk(2'h3, 8'h02);
    fork
      lap_link_peer_inst.send_ack();
    join_none
    @(negedge mclk);
    wait_irq(1'b1, 4 * B);
    check({7'h00, tx_irq}, 8'h01, "tx irq after ack");
    chk_time($realtime - lap_link_peer_inst.t_tx, 0.0, 3 * BT,
             "tx irq");
    rd_chk(2'h3, 8'h03);
    // stream of bytes, each written once ready is polled high
    auto_ack = 1'b1;
    for (int k = 0; k < 3; k++) begin
      q = 8'h00;
      for (int i = 0; i < 40 && q[0] !== 1'b1; i++)
        access(2'h3, 1'b1, 8'h00, q);
      check({7'h00, q[0]}, 8'h01, "ready before write");
      n0 = lap_link_peer_inst.n_data;
      wr(2'h1, 8'h81 ^ (8'h7e * k[7:0]));
      for (int i = 0; i < 14 * B && lap_link_peer_inst.n_data == n0; i++)
        @(negedge mclk);
      check(lap_link_peer_inst.rx_byte, 8'h81 ^ (8'h7e * k[7:0]),
            "stream byte");
    end
    repeat (6 * B) @(negedge mclk);
    rd_chk(2'h3, 8'h03);
    finish_test();
  end
endmodule
`default_nettype wire
